// ==== src/qsi_interface.v ====
// Contract
// - Two-bit active-low request code, one per cycle
// - Accept a new request every memory cycle
// - Write takes address, lane mask and word
// - Read takes address with read request bit
// - Read select and read address at rise
// - Write select, low half, then high half
// - Read address rising slot, write address falling
// - Read and write may share one cycle
// - Each mask bit guards one nine-bit lane
// - All lanes masked means no write
// - Word split, low half first, high second
// - Mask halves travel with their data halves
// - Address register: two slots per cycle
// - Capture both read halves, join into word
// - Read word ready four cycles after request
// - Two phases of one clock drive everything
`include "qsi_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module qsi_interface #(
    parameter ADDR_W     = `QSI_ADDR_W,
    parameter WORD_W     = `QSI_WORD_W,
    parameter HALF_W     = `QSI_HALF_W,
    parameter MASK_W     = `QSI_MASK_W,
    parameter HMASK_W    = `QSI_HALF_MASK_W,
    parameter LATENCY    = `QSI_READ_LATENCY,
    parameter LEAD       = `QSI_LAUNCH_LEAD
) (
    input  wire                  clock_in,
    input  wire                  resetn_in,
    // User side, same clock domain
    input  wire [1:0]            cmd_n_in,
    input  wire [ADDR_W-1:0]     read_location_in,
    input  wire [ADDR_W-1:0]     write_location_in,
    input  wire [WORD_W-1:0]     write_word_in,
    input  wire [MASK_W-1:0]     byte_lane_mask_n_in,
    output wire                  request_taken_out,
    output reg                   write_cancelled_out,
    output reg  [WORD_W-1:0]     read_word_out,
    output reg                   read_ready_out,
    // Memory side
    input  wire                  mem_clock_in,
    input  wire [HALF_W-1:0]     mem_read_data_in,
    output reg                   mem_clock_out,
    output reg                   mem_clock_n_out,
    output reg                   read_port_select_n_out,
    output reg                   write_port_select_n_out,
    output wire [ADDR_W-1:0]     mem_address_out,
    output wire [HALF_W-1:0]     mem_write_data_out,
    output wire [HMASK_W-1:0]    mem_lane_mask_n_out
);

    ////////////////////////////////////////////////////////////////////
    // Functions
    ////////////////////////////////////////////////////////////////////

    // Active-low request bit set in the code
    function asks;
        input [1:0]   code;
        input integer bit_index;
        begin
            asks = ~code[bit_index];
        end
    endfunction

    // A write that masks every lane changes nothing in memory
    function all_masked;
        input [MASK_W-1:0] mask_n;
        begin
            all_masked = &mask_n;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Memory clock phase tracking
    ////////////////////////////////////////////////////////////////////

    wire              k_stable;
    reg               k_prev;
    wire              rise_det;
    wire              fall_det;
    reg  [LEAD-1:0]   rise_lead;
    reg  [LEAD-1:0]   fall_lead;

    // Reference clock arrives from outside, so it passes the synchroniser
    qsi_sync3 #(
        .W          (1)
    ) u_clock_sync (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .async_in   (mem_clock_in),
        .stable_out (k_stable)
    );

    // Both phases come from edges of one reference, so they stay locked
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            k_prev <= 1'b0;
        end else begin
            k_prev <= k_stable;
        end
    end

    assign rise_det = k_stable & ~k_prev;
    assign fall_det = ~k_stable & k_prev;

    // Request is taken on each phase-0 slot; no request is ever refused
    assign request_taken_out = rise_det;

    // Delay lines that place the forwarded edges after the launch
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rise_lead <= {LEAD{1'b0}};
            fall_lead <= {LEAD{1'b0}};
        end else begin
            rise_lead <= {rise_lead[LEAD-2:0], rise_det};
            fall_lead <= {fall_lead[LEAD-2:0], fall_det};
        end
    end

    // Forwarded clock pair; the two outputs always stay complementary
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_clock_out   <= `QSI_CLOCK_IDLE;
            mem_clock_n_out <= ~`QSI_CLOCK_IDLE;
        end else if (rise_lead[LEAD-1]) begin
            mem_clock_out   <= 1'b1;
            mem_clock_n_out <= 1'b0;
        end else if (fall_lead[LEAD-1]) begin
            mem_clock_out   <= 1'b0;
            mem_clock_n_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request decode
    ////////////////////////////////////////////////////////////////////

    wire want_read;
    wire want_write;
    wire write_live;

    assign want_read  = asks(cmd_n_in, `QSI_CMD_READ_BIT);
    assign want_write = asks(cmd_n_in, `QSI_CMD_WRITE_BIT);
    // Fully masked write is dropped rather than sent
    assign write_live = want_write & ~all_masked(byte_lane_mask_n_in);

    ////////////////////////////////////////////////////////////////////
    // Port selects
    ////////////////////////////////////////////////////////////////////

    // Selects change only on a taken request, so after reset they stay
    // high until the first code arrives; each holds one memory cycle
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            read_port_select_n_out  <= `QSI_SELECT_IDLE;
            write_port_select_n_out <= `QSI_SELECT_IDLE;
            write_cancelled_out     <= 1'b0;
        end else if (rise_det) begin
            read_port_select_n_out  <= ~want_read;
            write_port_select_n_out <= ~write_live;
            write_cancelled_out     <= want_write & ~write_live;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Double-rate launch of address, data and mask
    ////////////////////////////////////////////////////////////////////

    // Shared address: read address in the rising slot, write address in
    // the falling slot; the register drives the write address two clock_in
    // cycles ahead of the edge that latches it
    qsi_ddr_out #(
        .W             (ADDR_W)
    ) u_address_ddr (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .load_in       (rise_det),
        .fall_in       (fall_det),
        .rise_value_in (read_location_in),
        .fall_value_in (write_location_in),
        .pin_out       (mem_address_out)
    );

    // Write word split; low half goes with the write select
    qsi_ddr_out #(
        .W             (HALF_W)
    ) u_data_ddr (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .load_in       (rise_det),
        .fall_in       (fall_det),
        .rise_value_in (write_word_in[HALF_W-1:0]),
        .fall_value_in (write_word_in[WORD_W-1:HALF_W]),
        .pin_out       (mem_write_data_out)
    );

    // Lane mask halves ride with their data halves; bit n guards
    // word bits 9n+8 down to 9n
    qsi_ddr_out #(
        .W             (HMASK_W)
    ) u_mask_ddr (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .load_in       (rise_det),
        .fall_in       (fall_det),
        .rise_value_in (byte_lane_mask_n_in[HMASK_W-1:0]),
        .fall_value_in (byte_lane_mask_n_in[MASK_W-1:HMASK_W]),
        .pin_out       (mem_lane_mask_n_out)
    );

    ////////////////////////////////////////////////////////////////////
    // Read return path
    ////////////////////////////////////////////////////////////////////

    wire [HALF_W-1:0]  q_stable;
    reg  [LATENCY-1:0] read_pipe;
    reg                high_pending;
    reg  [HALF_W-1:0]  low_half;
    reg  [WORD_W-1:0]  joined_word;
    reg  [WORD_W-1:0]  stage_word;

    // Read data bus comes from the memory pins, so it is synchronised
    qsi_sync3 #(
        .W          (HALF_W)
    ) u_data_sync (
        .clock_in   (clock_in),
        .resetn_in  (resetn_in),
        .async_in   (mem_read_data_in),
        .stable_out (q_stable)
    );

    // One bit per memory cycle marks a read in flight; back-to-back
    // reads each keep their own slot, so nothing stalls the user
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            read_pipe <= {LATENCY{1'b0}};
        end else if (rise_det) begin
            read_pipe <= {read_pipe[LATENCY-2:0], want_read};
        end
    end

    // Memory launches the halves at the rise and fall after the read;
    // the synchroniser delay means they are taken one cycle later still
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_half     <= {HALF_W{1'b0}};
            high_pending <= 1'b0;
        end else if (rise_det) begin
            high_pending <= read_pipe[`QSI_CAPTURE_STAGE];
            if (read_pipe[`QSI_CAPTURE_STAGE]) begin
                low_half <= q_stable;
            end
        end else if (fall_det) begin
            high_pending <= 1'b0;
        end
    end

    // Second half joins the first into the user word
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            joined_word <= {WORD_W{1'b0}};
        end else if (fall_det && high_pending) begin
            joined_word <= {q_stable, low_half};
        end
    end

    // Hold stage keeps the word safe from the next read's capture
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage_word <= {WORD_W{1'b0}};
        end else if (rise_det && read_pipe[`QSI_STAGE_HOLD]) begin
            stage_word <= joined_word;
        end
    end

    // Ready marks the word for one memory cycle, four after the request
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            read_word_out  <= {WORD_W{1'b0}};
            read_ready_out <= 1'b0;
        end else if (rise_det) begin
            read_ready_out <= read_pipe[LATENCY-1];
            if (read_pipe[LATENCY-1]) begin
                read_word_out <= stage_word;
            end
        end
    end

endmodule // qsi_interface

`default_nettype wire

// ==== src/qsi_regs.vh ====
`ifndef QSI_REGS_VH
`define QSI_REGS_VH

// Request code, active low: bit 1 asks for a write, bit 0 for a read
`define QSI_CMD_W             2
`define QSI_CMD_WRITE_BIT     1
`define QSI_CMD_READ_BIT      0
`define QSI_CMD_IDLE          2'h3
`define QSI_CMD_READ          2'h2
`define QSI_CMD_WRITE         2'h1
`define QSI_CMD_BOTH          2'h0

// Widths of the user word, the memory half word and the lane masks
`define QSI_ADDR_W            18
`define QSI_WORD_W            36
`define QSI_HALF_W            18
`define QSI_LANE_W            9
`define QSI_MASK_W            4
`define QSI_HALF_MASK_W       2
`define QSI_MASK_NONE         4'hf

// Memory cycles from read request to the ready word
`define QSI_READ_LATENCY      4

// Pipeline stage at which both halves of a read word are captured, then the stage at which the word is held
`define QSI_CAPTURE_STAGE     1
`define QSI_STAGE_HOLD        2

// Cycles of clock_in between a detected memory clock edge and the
// forwarded edge, so that address and data sit centred on it
`define QSI_LAUNCH_LEAD       2

// Reset values of the memory side
`define QSI_SELECT_IDLE       1'b1
`define QSI_CLOCK_IDLE        1'b0

`endif

// ==== src/qsi_sync3.v ====
`timescale 1ns/1ps
`default_nettype none

module qsi_sync3 #(
    parameter W = 1
) (
    input  wire         clock_in,
    input  wire         resetn_in,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] stable_out
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;

    // Three flops; a change counts only once stages two and three agree
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage1     <= {W{1'b0}};
            stage2     <= {W{1'b0}};
            stage3     <= {W{1'b0}};
            stable_out <= {W{1'b0}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                stable_out <= stage3;
            end
        end
    end

endmodule // qsi_sync3

`default_nettype wire

// ==== src/qsi_ddr_out.v ====
`timescale 1ns/1ps
`default_nettype none

module qsi_ddr_out #(
    parameter W = 18
) (
    input  wire         clock_in,
    input  wire         resetn_in,
    input  wire         load_in,
    input  wire         fall_in,
    input  wire [W-1:0] rise_value_in,
    input  wire [W-1:0] fall_value_in,
    output reg  [W-1:0] pin_out
);

    reg [W-1:0] fall_hold;

    // Both halves are loaded together; the second waits for the falling slot
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fall_hold <= {W{1'b0}};
            pin_out   <= {W{1'b0}};
        end else if (load_in) begin
            fall_hold <= fall_value_in;
            pin_out   <= rise_value_in;
        end else if (fall_in) begin
            pin_out <= fall_hold;
        end
    end

endmodule // qsi_ddr_out

`default_nettype wire

// ==== sim/qsi_interface_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsi_interface_props (
    input wire logic        clock_in,
    input wire logic        resetn_in,
    input wire logic [1:0]  cmd_n_in,
    input wire logic [17:0] read_location_in,
    input wire logic [35:0] write_word_in,
    input wire logic [3:0]  byte_lane_mask_n_in,
    input wire logic        request_taken_out,
    input wire logic        write_cancelled_out,
    input wire logic        read_ready_out,
    input wire logic        mem_clock_out,
    input wire logic        mem_clock_n_out,
    input wire logic        read_port_select_n_out,
    input wire logic        write_port_select_n_out,
    input wire logic [17:0] mem_address_out,
    input wire logic [17:0] mem_write_data_out,
    input wire logic [1:0]  mem_lane_mask_n_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    wire logic tk = request_taken_out;
    ////////////////////////////////////////////////////////////
    // Selects and first slot follow the request taken one cycle earlier
    reset_idle_a: assert property ($rose(resetn_in) |-> read_port_select_n_out && write_port_select_n_out && !read_ready_out) else $error("selects or ready active after reset");
    read_start_a: assert property (tk && !cmd_n_in[0] |=> !read_port_select_n_out && mem_address_out == $past(read_location_in)) else $error("read select or read address wrong");
    no_read_a: assert property (tk && cmd_n_in[0] |=> read_port_select_n_out) else $error("read select without read request");
    write_start_a: assert property (tk && !cmd_n_in[1] && byte_lane_mask_n_in != 4'hf |=> !write_port_select_n_out && mem_write_data_out == $past(write_word_in[17:0]) && mem_lane_mask_n_out == $past(byte_lane_mask_n_in[1:0])) else $error("write select or low half wrong");
    write_cancel_a: assert property (tk && !cmd_n_in[1] && byte_lane_mask_n_in == 4'hf |=> write_port_select_n_out && write_cancelled_out) else $error("masked write not cancelled");
    select_hold_a: assert property (!tk |=> $stable(read_port_select_n_out) && $stable(write_port_select_n_out)) else $error("select moved between requests");
    ready_slot_a: assert property ($rose(read_ready_out) |-> $past(tk)) else $error("ready rose off a memory cycle");
    clock_pair_a: assert property (mem_clock_n_out == !mem_clock_out) else $error("forwarded clock pair not complementary");
    taken_space_a: assert property (tk |=> !tk [*6]) else $error("request slots too close");
    cover property (tk && cmd_n_in == 2'h0);
    cover property (write_cancelled_out);
    cover property ($rose(read_ready_out));
endmodule // qsi_interface_props
bind qsi_interface qsi_interface_props u_props (.clock_in, .resetn_in, .cmd_n_in, .read_location_in, .write_word_in,
    .byte_lane_mask_n_in, .request_taken_out, .write_cancelled_out, .read_ready_out, .mem_clock_out, .mem_clock_n_out,
    .read_port_select_n_out, .write_port_select_n_out, .mem_address_out, .mem_write_data_out, .mem_lane_mask_n_out);
`default_nettype wire

// ==== sim/qsi_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsi_mem_model (
    input wire logic        k_in,
    input wire logic        rsel_n_in,
    input wire logic        wsel_n_in,
    input wire logic [17:0] addr_in,
    input wire logic [17:0] data_in,
    input wire logic [1:0]  mask_n_in,
    output var logic [17:0] q_out
);
    logic [35:0] mem [int]; // Sparse, 18-bit keys cover all 256K words
    logic [35:0] rword, w;
    logic [17:0] raddr, wlo;
    logic [1:0]  mlo;
    logic        rpend = 0, rret = 0, wpend = 0;
    initial q_out = 18'h0;
    ////////////////////////////////////////////////////////////
    // Rise: answer last read, take read address and low write half; only K times us
    always @(posedge k_in) begin
        rword = mem.exists(raddr) ? mem[raddr] : 36'h0;
        q_out <= rpend ? rword[17:0] : ~q_out;
        rret <= rpend;
        rpend <= !rsel_n_in;
        raddr <= addr_in;
        wpend <= !wsel_n_in;
        wlo <= data_in;
        mlo <= mask_n_in;
    end
    // Fall: second read half, write address and high half; idle Q toggles so stale data never matches
    always @(negedge k_in) begin
        q_out <= rret ? rword[35:18] : ~q_out;
        if (wpend) begin
            w = mem.exists(addr_in) ? mem[addr_in] : 36'h0;
            for (int i = 0; i < 4; i++)
                if (!({mask_n_in, mlo} >> i & 1)) w[9*i +: 9] = ({data_in, wlo} >> 9*i) & 9'h1ff;
            mem[addr_in] = w;
        end
    end
endmodule // qsi_mem_model
`default_nettype wire

// ==== sim/qdr_sram_interface_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module qdr_sram_interface_test;
    logic        clock_in = 0, resetn_in = 0, mem_clock_in = 0;
    logic [1:0]  cmd_n_in = 2'h3;
    logic [17:0] read_location_in = 0, write_location_in = 0;
    logic [35:0] write_word_in = 0;
    logic [3:0]  byte_lane_mask_n_in = 4'hf;
    wire logic        taken, cancelled, ready, k, k_n, rsel_n, wsel_n;
    wire logic [35:0] read_word;
    wire logic [17:0] addr, wdata, q;
    wire logic [1:0]  mask_n;
    int n_errors = 0, compares = 0;
    always #2 clock_in = ~clock_in;
    // Link clock with an odd offset so its edges never line up with ours
    initial begin
        #1.3;
        forever #16 mem_clock_in = ~mem_clock_in;
    end
    qsi_interface u_dut (.clock_in, .resetn_in, .cmd_n_in, .read_location_in, .write_location_in, .write_word_in,
        .byte_lane_mask_n_in, .request_taken_out(taken), .write_cancelled_out(cancelled), .read_word_out(read_word),
        .read_ready_out(ready), .mem_clock_in, .mem_read_data_in(q), .mem_clock_out(k), .mem_clock_n_out(k_n),
        .read_port_select_n_out(rsel_n), .write_port_select_n_out(wsel_n), .mem_address_out(addr),
        .mem_write_data_out(wdata), .mem_lane_mask_n_out(mask_n));
    qsi_mem_model u_mem (.k_in(k), .rsel_n_in(rsel_n), .wsel_n_in(wsel_n), .addr_in(addr), .data_in(wdata),
        .mask_n_in(mask_n), .q_out(q));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds one request until its slot is taken, then goes idle
    task automatic req(input logic [1:0] c, input logic [17:0] ra, input logic [17:0] wa,
                       input logic [35:0] wd, input logic [3:0] m);
        @(negedge clock_in);
        cmd_n_in = c;
        read_location_in = ra;
        write_location_in = wa;
        write_word_in = wd;
        byte_lane_mask_n_in = m;
        // Taken is looked at mid-cycle, away from the edge that moves it
        for (int i = 0; i < 40; i++) begin
            @(negedge clock_in);
            if (taken === 1'b1) break;
        end
        @(negedge clock_in);
        cmd_n_in = 2'h3;
    endtask
    // Counts memory slots until ready and compares the joined word
    task automatic wait_ready(input logic [35:0] exp);
        int n;
        n = 0;
        for (int i = 0; i < 100; i++) begin
            @(negedge clock_in);
            if (ready === 1'b1) break;
            if (taken === 1'b1) n++;
        end
        chk(n, 4);
        chk(read_word, exp);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({rsel_n, wsel_n, ready}, 3'h6);
    endtask
    // Write then read in the very next slot
    task automatic t_write_read;
        req(2'h1, 0, 18'h00a5, 36'h1_2345_6789, 4'h0);
        req(2'h2, 18'h00a5, 0, 0, 4'hf);
        wait_ready(36'h1_2345_6789);
    endtask
    // Each lane alone over a known background
    task automatic t_lanes;
        logic [35:0] e;
        for (int i = 0; i < 4; i++) begin
            req(2'h1, 0, 18'h3ffff, 36'hf_ffff_ffff, 4'h0);
            req(2'h1, 0, 18'h3ffff, 36'h0, ~(4'h1 << i));
            e = 36'hf_ffff_ffff;
            e[9*i +: 9] = 9'h0;
            req(2'h2, 18'h3ffff, 0, 0, 4'hf);
            wait_ready(e);
        end
    endtask
    task automatic t_cancel;
        req(2'h1, 0, 18'h00a5, 36'h0, 4'hf);
        chk(cancelled, 1'b1);
        req(2'h2, 18'h00a5, 0, 0, 4'hf);
        wait_ready(36'h1_2345_6789);
    endtask
    // Read and write in one slot, same and different places
    task automatic t_both;
        req(2'h0, 18'h00a5, 18'h00a5, 36'h8_7654_3210, 4'h0);
        wait_ready(36'h8_7654_3210);
        req(2'h0, 18'h3ffff, 18'h1, 36'h5_a5a5_a5a5, 4'h0);
        wait_ready(36'h0_07ff_ffff);
        req(2'h2, 18'h1, 0, 0, 4'hf);
        wait_ready(36'h5_a5a5_a5a5);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole sequence needs about 2 us; cut a hang well beyond that
    initial begin
        #50000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clock_in);
        resetn_in = 1;
        t_reset();
        t_write_read();
        t_lanes();
        t_cancel();
        t_both();
        summarize();
    end
endmodule // qdr_sram_interface_test
`default_nettype wire
